// ### logic/watchdog_defs.vh
// Purpose: Constants for the watchdog and frequency recovery block.
// Assumes: 100 MHz system clock.
// Notes:   Times are given in their own unit; cycle counts derive from them.
`ifndef WATCHDOG_DEFS_VH
`define WATCHDOG_DEFS_VH

// =====================================================================
// Clock and timing
`define CLK_PERIOD_NS        10
`define UNIT_SHORT_MS        150
`define UNIT_LONG_MS         2500
// Divide first so the long unit does not overflow a 32-bit integer.
`define UNIT_SHORT_CYC       (`UNIT_SHORT_MS * (1000000 / `CLK_PERIOD_NS))
`define UNIT_LONG_CYC        (`UNIT_LONG_MS * (1000000 / `CLK_PERIOD_NS))
`define RESET_PULSE_CYC      16

// =====================================================================
// Frequency formula
`define FREQ_OFFSET          3
`define GEAR_MILLI_DEFAULT   48007
`define STRAP_DEFAULT        5'h00
`define TIMEOUT_RESET        5'h00
`define NUM_RESET            8'h00
`define DEN_RESET            7'h00

`endif

// ### logic/unit_tick.v
// Purpose: Divider making a one-cycle tick every timer unit.
// Assumes: Restart aligns the tick phase with the start of a countdown.
// Notes:   The unit length is chosen by the prescale select.
`timescale 1ns/1ps
module unit_tick #(
  parameter integer SHORT_CYC = 15000000,
  parameter integer LONG_CYC  = 250000000
) (
  // Clock and reset
  input  wire sys_clk_i,
  input  wire sys_rst_i,
  // Control
  input  wire restart_i,
  input  wire long_i,
  // Tick
  output reg  tick_o
);

  reg [31:0] count_r;
  wire [31:0] limit = long_i ? LONG_CYC[31:0] - 32'h0000_0001 : SHORT_CYC[31:0] - 32'h0000_0001;

  // =====================================================================
  // Divider
  always @(posedge sys_clk_i) begin
    if (sys_rst_i || restart_i) begin
      count_r <= 32'h0000_0000;
      tick_o  <= 1'b0;
    end else if (count_r >= limit) begin
      count_r <= 32'h0000_0000;
      tick_o  <= 1'b1;
    end else begin
      count_r <= count_r + 32'h0000_0001;
      tick_o  <= 1'b0;
    end
  end

endmodule // unit_tick

// ### logic/freq_calc.v
// Purpose: Computes the target CPU frequency from gear, N and M.
// Assumes: Software keeps (N+3)/(M+3) above one.
// Notes:   Result is in kHz, registered; gear is given in kHz.
`timescale 1ns/1ps
module freq_calc (
  // Clock and reset
  input  wire        sys_clk_i,
  input  wire        sys_rst_i,
  // Operands
  input  wire [31:0] gear_khz_i,
  input  wire [7:0]  num_i,
  input  wire [6:0]  den_i,
  // Result
  output reg  [31:0] freq_khz_o
);

  wire [8:0]  n3   = {1'b0, num_i} + 9'h003;
  wire [7:0]  m3   = {1'b0, den_i} + 8'h03;
  wire [40:0] prod = gear_khz_i * n3;
  wire [40:0] quot = prod / {33'h0_0000_0000, m3};

  // =====================================================================
  // Registered quotient
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      freq_khz_o <= 32'h0000_0000;
    end else begin
      freq_khz_o <= quot[31:0];
    end
  end

endmodule // freq_calc

// ### logic/watchdog_freq_recovery.v
// Purpose: Watchdog timer with recovery frequency and reset pulse generation.
// Assumes: Register writes arrive as strobes from the serial management decoder.
// Notes:   Frequency output is a computed kHz figure for the clock synthesiser when N and M are in use, and zero in table mode.
`timescale 1ns/1ps
`include "watchdog_defs.vh"

module watchdog_freq_recovery #(
  parameter integer UNIT_SHORT_CYC  = `UNIT_SHORT_CYC,
  parameter integer UNIT_LONG_CYC   = `UNIT_LONG_CYC,
  parameter integer RESET_PULSE_CYC = `RESET_PULSE_CYC,
  parameter [31:0]  GEAR_KHZ        = `GEAR_MILLI_DEFAULT
) (
  // Clock and reset
  input  wire        sys_clk_i,
  input  wire        sys_rst_i,
  // Straps and latch
  input  wire [4:0]  strap_frequency_select_i,
  input  wire        strap_latch_i,
  // Control byte fields
  input  wire        ctrl_wr_i,
  input  wire [4:0]  watchdog_timeout_value_i,
  input  wire        watchdog_prescale_select_i,
  input  wire        reset_on_expiry_enable_i,
  input  wire        reset_on_freq_change_enable_i,
  input  wire        watchdog_enable_i,
  input  wire        recovery_source_select_i,
  input  wire        select_source_override_i,
  input  wire        prog_freq_enable_i,
  input  wire [4:0]  select_bits_i,
  input  wire        flag_wr_i,
  input  wire        flag_wdata_i,
  // Frequency values
  input  wire        cpu_num_wr_i,
  input  wire [7:0]  cpu_numerator_value_i,
  input  wire        cpu_den_wr_i,
  input  wire [6:0]  cpu_denominator_value_i,
  input  wire        rec_num_wr_i,
  input  wire [7:0]  recovery_numerator_value_i,
  input  wire        rec_den_wr_i,
  input  wire [6:0]  recovery_denominator_value_i,
  // Status and readback
  output wire        watchdog_timeout_flag_o,
  output wire [4:0]  watchdog_timeout_value_o,
  output wire        watchdog_prescale_select_o,
  output wire        reset_on_expiry_enable_o,
  output wire        reset_on_freq_change_enable_o,
  output wire        recovery_active_o,
  // Frequency and reset
  output reg  [4:0]  active_select_o,
  output reg         freq_change_o,
  output wire [31:0] cpu_freq_khz_o,
  output reg         sys_reset_o
);

  localparam ST_IDLE = 2'd0;
  localparam ST_ARM  = 2'd1;
  localparam ST_RUN  = 2'd2;
  localparam ST_DONE = 2'd3;

  // =====================================================================
  // Registers
  reg [4:0] timeout_r;
  reg       prescale_r;
  reg       rst_watchdog_enable_r;
  reg       rst_fc_en_r;
  reg       watchdog_enable_r;
  reg       rec_sel_r;
  reg       override_r;
  reg       prog_en_r;
  reg [4:0] sel_r;
  reg [4:0] strap_r;
  reg [7:0] cpu_n_r;
  reg [6:0] cpu_m_r;
  reg [7:0] rec_n_r;
  reg [6:0] rec_m_r;
  reg       flag_r;
  reg       recovery_r;
  reg [1:0] state_r;
  reg [5:0] count_r;
  reg [7:0] pulse_r;

  wire tick;
  wire expire = (state_r == ST_RUN) && tick && (count_r == 6'd1);
  wire fchange = cpu_num_wr_i || cpu_den_wr_i || ((rec_num_wr_i || rec_den_wr_i) && recovery_r);

  function [4:0] pick_select;
    input       ovr;
    input [4:0] sel;
    input [4:0] strap;
    begin
      pick_select = ovr ? sel : strap;
    end
  endfunction

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      timeout_r   <= `TIMEOUT_RESET;
      prescale_r  <= 1'b0;
      rst_watchdog_enable_r <= 1'b0;
      rst_fc_en_r <= 1'b0;
      watchdog_enable_r     <= 1'b0;
      rec_sel_r   <= 1'b0;
      override_r  <= 1'b0;
      prog_en_r   <= 1'b0;
      sel_r       <= 5'h00;
    end else if (ctrl_wr_i) begin
      timeout_r   <= watchdog_timeout_value_i;
      prescale_r  <= watchdog_prescale_select_i;
      rst_watchdog_enable_r <= reset_on_expiry_enable_i;
      rst_fc_en_r <= reset_on_freq_change_enable_i;
      watchdog_enable_r     <= watchdog_enable_i;
      rec_sel_r   <= recovery_source_select_i;
      override_r  <= select_source_override_i;
      prog_en_r   <= prog_freq_enable_i;
      sel_r       <= select_bits_i;
    end
  end

  // Straps are caught by a clocked process so that reset takes only constants.
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      strap_r <= `STRAP_DEFAULT;
    end else if (strap_latch_i) begin
      strap_r <= strap_frequency_select_i;
    end
  end

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cpu_n_r <= `NUM_RESET;
      cpu_m_r <= `DEN_RESET;
      rec_n_r <= `NUM_RESET;
      rec_m_r <= `DEN_RESET;
    end else begin
      if (cpu_num_wr_i) cpu_n_r <= cpu_numerator_value_i;
      if (cpu_den_wr_i) cpu_m_r <= cpu_denominator_value_i;
      if (rec_num_wr_i) rec_n_r <= recovery_numerator_value_i;
      if (rec_den_wr_i) rec_m_r <= recovery_denominator_value_i;
    end
  end

  // =====================================================================
  // Watchdog countdown
  unit_tick #(
    .SHORT_CYC (UNIT_SHORT_CYC),
    .LONG_CYC  (UNIT_LONG_CYC)
  ) u_tick (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .restart_i (state_r != ST_RUN),
    .long_i    (prescale_r),
    .tick_o    (tick)
  );

  always @(posedge sys_clk_i) begin
    if (sys_rst_i || !watchdog_enable_r) begin
      state_r <= ST_IDLE;
      count_r <= {1'b0, timeout_r} + 6'd1;
    end else begin
      case (state_r)
        ST_IDLE: begin
          state_r <= ST_ARM;
        end
        ST_ARM: begin
          count_r <= {1'b0, timeout_r} + 6'd1;
          if (fchange && !recovery_r) begin
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (tick) begin
            count_r <= count_r - 6'd1;
            if (count_r == 6'd1) begin
              state_r <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          // Expired once; stays put until disabled so a hung system is not reset repeatedly.
          state_r <= ST_DONE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Set wins over a software clear in the same cycle.
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      flag_r <= 1'b0;
    end else if (expire) begin
      flag_r <= 1'b1;
    end else if (flag_wr_i && flag_wdata_i) begin
      flag_r <= 1'b0;
    end
  end

  // =====================================================================
  // Frequency selection
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      recovery_r <= 1'b0;
    end else if (expire) begin
      recovery_r <= 1'b1;
    end else if (cpu_num_wr_i || cpu_den_wr_i) begin
      recovery_r <= 1'b0;
    end
  end

  wire       use_strap_rec = recovery_r && !rec_sel_r;
  wire       use_nm        = recovery_r ? rec_sel_r : prog_en_r;
  wire [7:0] n_sel         = recovery_r ? rec_n_r : cpu_n_r;
  wire [6:0] m_sel         = recovery_r ? rec_m_r : cpu_m_r;
  wire [31:0] freq_raw;

  freq_calc u_calc (
    .sys_clk_i  (sys_clk_i),
    .sys_rst_i  (sys_rst_i),
    .gear_khz_i (GEAR_KHZ),
    .num_i      (n_sel),
    .den_i      (m_sel),
    .freq_khz_o (freq_raw)
  );

  // Zero reports a table-driven frequency chosen by active_select_o.
  assign cpu_freq_khz_o = use_nm ? freq_raw : 32'h0000_0000;

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      active_select_o <= 5'h00;
      freq_change_o   <= 1'b0;
    end else begin
      active_select_o <= use_strap_rec ? strap_r : pick_select(override_r, sel_r, strap_r);
      freq_change_o   <= fchange || expire;
    end
  end

  // =====================================================================
  // Reset pulse
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pulse_r     <= 8'h00;
      sys_reset_o <= 1'b0;
    end else if ((expire && rst_watchdog_enable_r) || (fchange && rst_fc_en_r)) begin
      pulse_r     <= RESET_PULSE_CYC[7:0] - 8'h01;
      sys_reset_o <= 1'b1;
    end else if (pulse_r != 8'h00) begin
      pulse_r     <= pulse_r - 8'h01;
      sys_reset_o <= 1'b1;
    end else begin
      sys_reset_o <= 1'b0;
    end
  end

  assign watchdog_timeout_flag_o       = flag_r;
  assign watchdog_timeout_value_o      = timeout_r;
  assign watchdog_prescale_select_o    = prescale_r;
  assign reset_on_expiry_enable_o      = rst_watchdog_enable_r;
  assign reset_on_freq_change_enable_o = rst_fc_en_r;
  assign recovery_active_o             = recovery_r;

endmodule // watchdog_freq_recovery

// ### verif/watchdog_props.sv
// Purpose: Port checker for the watchdog and frequency recovery block.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Pulse length is checked on a helper counter, not by repetition.
`timescale 1ns/1ps
// ======================================================================
// Checker
module watchdog_props #(
  parameter integer RESET_PULSE_CYC = 16
) (
  // Clock and reset
  input wire logic       sys_clk_i,
  input wire logic       sys_rst_i,
  // Strobes
  input wire logic       ctrl_wr_i,
  input wire logic [4:0] watchdog_timeout_value_i,
  input wire logic       flag_wr_i,
  input wire logic       flag_wdata_i,
  input wire logic       cpu_num_wr_i,
  input wire logic       cpu_den_wr_i,
  // Outputs
  input wire logic       watchdog_timeout_flag_o,
  input wire logic [4:0] watchdog_timeout_value_o,
  input wire logic       reset_on_expiry_enable_o,
  input wire logic       reset_on_freq_change_enable_o,
  input wire logic       recovery_active_o,
  input wire logic       freq_change_o,
  input wire logic       sys_reset_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // A counter instead of a long repetition keeps the tools fast.
  reg [7:0] hi_r;
  always @(posedge sys_clk_i) begin
    hi_r <= (sys_rst_i || !sys_reset_o) ? 8'h00 : hi_r + 8'h01;
  end
  flag_hold_a: assert property (watchdog_timeout_flag_o && !(flag_wr_i && flag_wdata_i) |=> watchdog_timeout_flag_o)
    else $error("timeout flag dropped without a clear");
  flag_clear_a: assert property ($fell(watchdog_timeout_flag_o) |-> $past(flag_wr_i) && $past(flag_wdata_i))
    else $error("timeout flag cleared without a write of one");
  expiry_flag_a: assert property ($rose(recovery_active_o) |-> watchdog_timeout_flag_o)
    else $error("expiry without timeout flag");
  expiry_rst_a: assert property ($rose(recovery_active_o) && reset_on_expiry_enable_o |-> sys_reset_o)
    else $error("expiry gave no reset pulse");
  fc_reset_a: assert property (freq_change_o && reset_on_freq_change_enable_o |-> sys_reset_o)
    else $error("frequency change gave no reset pulse");
  no_reset_a: assert property (!reset_on_expiry_enable_o && !reset_on_freq_change_enable_o && !sys_reset_o |=> !sys_reset_o)
    else $error("reset pulse while both enables are off");
  pulse_len_a: assert property ($fell(sys_reset_o) |-> hi_r == RESET_PULSE_CYC)
    else $error("reset pulse has the wrong length");
  value_rb_a: assert property (ctrl_wr_i |=> watchdog_timeout_value_o == $past(watchdog_timeout_value_i))
    else $error("timeout value readback wrong");
  rec_end_a: assert property (cpu_num_wr_i || cpu_den_wr_i |=> !recovery_active_o)
    else $error("recovery stays after a CPU write");
endmodule // watchdog_props

bind watchdog_freq_recovery watchdog_props #(.RESET_PULSE_CYC(RESET_PULSE_CYC)) props_inst (
  .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .ctrl_wr_i(ctrl_wr_i),
  .watchdog_timeout_value_i(watchdog_timeout_value_i), .flag_wr_i(flag_wr_i), .flag_wdata_i(flag_wdata_i),
  .cpu_num_wr_i(cpu_num_wr_i), .cpu_den_wr_i(cpu_den_wr_i), .watchdog_timeout_flag_o(watchdog_timeout_flag_o),
  .watchdog_timeout_value_o(watchdog_timeout_value_o), .reset_on_expiry_enable_o(reset_on_expiry_enable_o),
  .reset_on_freq_change_enable_o(reset_on_freq_change_enable_o), .recovery_active_o(recovery_active_o),
  .freq_change_o(freq_change_o), .sys_reset_o(sys_reset_o));

// ### verif/fw_host.sv
// Purpose: Firmware host model issuing control byte writes.
// Assumes: Each write is a one-cycle strobe launched after a rising edge.
// Notes:   Data stays put after the strobe edge has passed.
`timescale 1ns/1ps
// ======================================================================
// Host model
module fw_host (
  // Clock
  input wire logic sys_clk_i
);
  reg        ctrl_wr = 1'h0;
  reg [16:0] cv      = 17'h0_0000;
  reg        flag_wr = 1'h0;
  reg        flag_d  = 1'h0;
  reg [3:0]  nm_wr   = 4'h0;
  reg [7:0]  nm_d    = 8'h00;
  reg        latch   = 1'h0;
  reg [4:0]  strap   = 5'h00;
  task automatic ctrl(input [16:0] v);
    @(posedge sys_clk_i);
    ctrl_wr <= 1'h1;
    cv      <= v;
    @(posedge sys_clk_i);
    ctrl_wr <= 1'h0;
  endtask
  // Callers keep N above M and hold M at 93 or 48.
  task automatic wr_nm(input [1:0] k, input [7:0] d);
    @(posedge sys_clk_i);
    nm_wr <= 4'h1 << k;
    nm_d  <= d;
    @(posedge sys_clk_i);
    nm_wr <= 4'h0;
  endtask
  task automatic flag(input d);
    @(posedge sys_clk_i);
    flag_wr <= 1'h1;
    flag_d  <= d;
    @(posedge sys_clk_i);
    flag_wr <= 1'h0;
  endtask
  task automatic strap_set(input [4:0] s);
    @(posedge sys_clk_i);
    latch <= 1'h1;
    strap <= s;
    @(posedge sys_clk_i);
    latch <= 1'h0;
  endtask
endmodule // fw_host

// ### verif/tb_watchdog_freq_recovery.sv
// Purpose: Self-checking bench for the watchdog and frequency recovery block.
// Assumes: Short timer units of 10 and 20 cycles.
// Notes:   Expiry times are checked in a small window around the nominal count.
`timescale 1ns/1ps
`include "watchdog_defs.vh"
// ======================================================================
// Bench
module tb_watchdog_freq_recovery;
  reg          sys_clk_i = 1'h0;
  reg          sys_rst_i = 1'h1;
  wire         flag_o, pre_o, rwd_o, rfc_o, rec_o, fc_o, srst_o;
  wire [4:0]   tmo_o, act_o;
  wire [31:0]  freq_o;
  integer      n_fail = 0;
  integer      checks_done = 0;
  integer      n;
  always #5 sys_clk_i = ~sys_clk_i;
  fw_host fw (.sys_clk_i(sys_clk_i));
  watchdog_freq_recovery #(.UNIT_SHORT_CYC(10), .UNIT_LONG_CYC(20), .RESET_PULSE_CYC(16)) watchdog_freq_recovery_inst (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .strap_frequency_select_i(fw.strap), .strap_latch_i(fw.latch),
    .ctrl_wr_i(fw.ctrl_wr), .watchdog_timeout_value_i(fw.cv[16:12]), .watchdog_prescale_select_i(fw.cv[11]),
    .reset_on_expiry_enable_i(fw.cv[10]), .reset_on_freq_change_enable_i(fw.cv[9]), .watchdog_enable_i(fw.cv[8]),
    .recovery_source_select_i(fw.cv[7]), .select_source_override_i(fw.cv[6]), .prog_freq_enable_i(fw.cv[5]),
    .select_bits_i(fw.cv[4:0]), .flag_wr_i(fw.flag_wr), .flag_wdata_i(fw.flag_d),
    .cpu_num_wr_i(fw.nm_wr[0]), .cpu_numerator_value_i(fw.nm_d), .cpu_den_wr_i(fw.nm_wr[1]),
    .cpu_denominator_value_i(fw.nm_d[6:0]), .rec_num_wr_i(fw.nm_wr[2]), .recovery_numerator_value_i(fw.nm_d),
    .rec_den_wr_i(fw.nm_wr[3]), .recovery_denominator_value_i(fw.nm_d[6:0]), .watchdog_timeout_flag_o(flag_o),
    .watchdog_timeout_value_o(tmo_o), .watchdog_prescale_select_o(pre_o), .reset_on_expiry_enable_o(rwd_o),
    .reset_on_freq_change_enable_o(rfc_o), .recovery_active_o(rec_o), .active_select_o(act_o),
    .freq_change_o(fc_o), .cpu_freq_khz_o(freq_o), .sys_reset_o(srst_o));
  function [31:0] f(input integer nv, input integer mv);
    f = `GEAR_MILLI_DEFAULT * (nv + 3) / (mv + 3);
  endfunction
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input [8*10:1] nm, input [31:0] e, input [31:0] g);
    checks_done = checks_done + 1;
    if (g !== e) begin
      n_fail = n_fail + 1;
      $display("unexpected %0s exp %0h got %0h", nm, e, g);
    end
  endtask
  task tick(input integer c);
    repeat (c) @(posedge sys_clk_i);
    #1;
  endtask
  // Counts edges until recovery shows; a missing expiry ends the run.
  task wait_rec;
    n = 0;
    while (rec_o !== 1'h1 && n < 2000) begin
      tick(1);
      n = n + 1;
    end
    if (n >= 2000) begin
      n_fail = n_fail + 1;
      tally_and_finish;
    end
  endtask
  task t_prog;
    fw.ctrl({5'h1F, 7'h03, 5'h15});
    tick(2);
    chk("tmo_rb", 32'h0000_001F, tmo_o);
    fw.wr_nm(0, 8'h61);
    fw.wr_nm(1, 8'h5D);
    tick(4);
    chk("freq_lo", f(97, 93), freq_o);
    chk("sel_ovr", 32'h0000_0015, act_o);
    chk("no_rst", 32'h0000_0000, srst_o);
    fw.ctrl({5'h1F, 7'h01, 5'h0C});
    fw.wr_nm(0, 8'h7F);
    fw.wr_nm(1, 8'h30);
    tick(4);
    chk("sel_strap", 32'h0000_000A, act_o);
    chk("freq_hi", f(127, 48), freq_o);
    $display("t_prog ended");
  endtask
  task t_fc;
    fw.ctrl({5'h00, 7'h13, 5'h15});
    tick(2);
    fw.wr_nm(0, 8'h80);
    tick(3);
    chk("fc_rst", 32'h0000_0001, srst_o);
    tick(20);
    chk("fc_end", 32'h0000_0000, srst_o);
    $display("t_fc ended");
  endtask
  task t_short;
    fw.ctrl({5'h02, 7'h2B, 5'h15});
    tick(3);
    fw.wr_nm(0, 8'h90);
    wait_rec;
    chk("short_cyc", 32'h0000_0001, (n >= 30 && n <= 35));
    // The active select register follows the recovery switch one cycle later.
    tick(1);
    chk("flag_set", 32'h0000_0001, flag_o);
    chk("wd_rst", 32'h0000_0001, srst_o);
    chk("rec_strap", 32'h0000_000A, act_o);
    fw.flag(1'h0);
    tick(1);
    chk("flag_w0", 32'h0000_0001, flag_o);
    fw.flag(1'h1);
    tick(1);
    chk("flag_w1", 32'h0000_0000, flag_o);
    fw.wr_nm(0, 8'h90);
    tick(2);
    chk("rec_end", 32'h0000_0000, rec_o);
    $display("t_short ended");
  endtask
  task t_long;
    fw.ctrl({5'h01, 7'h00, 5'h15});
    tick(1);
    chk("tbl_freq", 32'h0000_0000, freq_o);
    fw.ctrl({5'h01, 7'h47, 5'h15});
    fw.ctrl({5'h01, 7'h4F, 5'h15});
    tick(3);
    chk("pre_rb", 32'h0000_0001, pre_o);
    fw.wr_nm(2, 8'h7F);
    fw.wr_nm(3, 8'h30);
    fw.wr_nm(0, 8'h90);
    wait_rec;
    chk("long_cyc", 32'h0000_0001, (n >= 40 && n <= 45));
    tick(4);
    chk("rec_freq", f(127, 48), freq_o);
    chk("no_wd_rst", 32'h0000_0000, srst_o);
    fw.ctrl({5'h01, 7'h23, 5'h15});
    fw.wr_nm(0, 8'h90);
    tick(80);
    chk("wd_off", 32'h0000_0000, rec_o);
    chk("flag_keep", 32'h0000_0001, flag_o);
    $display("t_long ended");
  endtask
  task t_rst;
    sys_rst_i <= 1'h1;
    tick(2);
    sys_rst_i <= 1'h0;
    tick(1);
    chk("rst_flag2", 32'h0000_0000, flag_o);
    chk("rst_tmo", 32'h0000_0000, tmo_o);
    $display("t_rst ended");
  endtask
  initial begin
    tick(4);
    sys_rst_i <= 1'h0;
    tick(1);
    chk("rst_flag", 32'h0000_0000, flag_o);
    fw.strap_set(5'h0A);
    t_prog;
    t_fc;
    t_short;
    t_long;
    t_rst;
    tally_and_finish;
  end
endmodule // tb_watchdog_freq_recovery
